//--- pkg/bsr_pkg.sv
/*
  bsr_pkg: fault codes, status layout, argument limits, serial timing
  and carrier types for the bus/serial fault reporter.
  Assumes a 50 MHz system clock and arguments given in 10 us units.
*/
package bsr_pkg;

  // instrument-bus fault codes
  localparam logic [4:0] BUS_NO_FAULT_CODE          = 5'h00;
  localparam logic [4:0] NOT_CONTROLLER_FAULT       = 5'h01;
  localparam logic [4:0] NO_LISTENER_FAULT          = 5'h02;
  localparam logic [4:0] UNADDRESSED_FAULT          = 5'h03;
  localparam logic [4:0] BAD_ARGUMENT_FAULT         = 5'h04;
  localparam logic [4:0] NO_SYSTEM_CONTROLLER_FAULT = 5'h05;
  localparam logic [4:0] IO_ABORTED_FAULT           = 5'h06;
  localparam logic [4:0] CAPABILITY_DISABLED_FAULT  = 5'h0B;
  localparam logic [4:0] COMMAND_BYTE_FAULT         = 5'h0E;
  localparam logic [4:0] UNKNOWN_FUNCTION_FAULT     = 5'h11;

  // serial-link fault codes
  localparam logic [2:0] LINK_NO_FAULT_CODE    = 3'h0;
  localparam logic [2:0] PARITY_FAULT          = 3'h1;
  localparam logic [2:0] OVERRUN_FAULT         = 3'h2;
  localparam logic [2:0] BUFFER_OVERFLOW_FAULT = 3'h3;
  localparam logic [2:0] FRAMING_FAULT         = 3'h4;

  // status word: fault flag is the sign bit (-32768)
  localparam int unsigned STATUS_FAULT_POS = 15;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;

  // serial timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned BAUD_BPS       = 9600;
  localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD_BPS;
  localparam int unsigned DATA_BITS      = 8;

  // argument limits, 10 us units (.00001 s, .0001 s, 3600 s)
  localparam logic [31:0] TMO_MIN   = 32'h0000_0001;
  localparam logic [31:0] SIC_MIN   = 32'h0000_000A;
  localparam logic [31:0] TIME_MAX  = 32'h1575_2A00;
  localparam logic [31:0] CADDR_BAD = 32'h0000_001F;

  // message terminators
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;

  // decoded function of a programming message
  typedef enum logic [3:0] {
    FN_NONE, FN_TMO, FN_SIC, FN_SRE, FN_CADDR, FN_GTS, FN_GTS_SHADOW,
    FN_WRT, FN_RD, FN_CMD, FN_RSC, FN_SPIGN, FN_OTHER
  } bsr_func_t;

  // one-hot states
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} bsr_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
  } bsr_rx_state_t;

  typedef struct packed {
    bsr_func_t   func;
    logic [31:0] arg;
    logic        needs_cic;
    logic        mode_mismatch;
    logic        unknown_name;
  } bsr_req_t;

  typedef struct packed {
    logic is_cic;
    logic atn;
    logic talk_addr;
    logic listen_addr;
  } bsr_bus_t;

  typedef struct packed {
    logic timed_out;
    logic cancelled;
    logic atn_taken;
    logic no_acceptor;
    logic no_listener;
    logic cmd_phase_fail;
  } bsr_io_t;

  typedef struct packed {
    logic smode;
    logic par_en;
    logic par_odd;
  } bsr_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bsr_chr_t;

endpackage : bsr_pkg

//--- rtl/bsr_bus_classify.sv
/*
  bsr_bus_classify: combinational instrument-bus fault classifier.
  Assumes its caller registers the result and picks the phase.
*/
`timescale 1ns/10ps
`default_nettype none
module bsr_bus_classify
  import bsr_pkg::*;
(
  // request and bus state
  input  wire bsr_req_t   req,
  input  wire bsr_bus_t   bus,
  input  wire bsr_io_t    io,
  input  wire logic       post,
  input  wire logic       sys_ctrl,
  // result
  output logic [4:0]      code
);

  logic arg_bad; // argument outside its legal range

  // range checks on arguments
  always_comb begin
    arg_bad = 1'b0;
    if (req.func == FN_TMO) begin
      arg_bad = (req.arg < TMO_MIN) || (req.arg > TIME_MAX); // see R7
    end else if (req.func == FN_SIC) begin
      arg_bad = (req.arg < SIC_MIN) || (req.arg > TIME_MAX); // see R7
    end else if (req.func == FN_CADDR) begin
      arg_bad = (req.arg == CADDR_BAD); // see R7
    end
  end

  // priority chain, earliest check first
  always_comb begin
    code = BUS_NO_FAULT_CODE; // see R3
    if (!post) begin
      if (req.unknown_name) begin
        code = UNKNOWN_FUNCTION_FAULT; // see R13
      end else if (req.mode_mismatch) begin
        code = CAPABILITY_DISABLED_FAULT; // see R11
      end else if (arg_bad) begin
        code = BAD_ARGUMENT_FAULT; // see R7
      end else if (!sys_ctrl && (req.func == FN_SIC || req.func == FN_SRE)) begin
        code = NO_SYSTEM_CONTROLLER_FAULT; // see R9
      end else if (req.needs_cic && !bus.is_cic) begin
        code = NOT_CONTROLLER_FAULT; // see R4
      end else if (!bus.is_cic && ((req.func == FN_WRT && !bus.talk_addr)
                   || (req.func == FN_RD && !bus.listen_addr))) begin
        code = UNADDRESSED_FAULT; // see R6
      end else if (req.func == FN_GTS_SHADOW && !bus.atn) begin
        code = UNADDRESSED_FAULT; // see R6
      end
    end else begin
      if (io.cmd_phase_fail) begin
        code = COMMAND_BYTE_FAULT; // see R12
      end else if ((req.func == FN_CMD && io.no_acceptor)
                   || (req.func == FN_WRT && (io.no_listener || io.atn_taken))) begin
        code = NO_LISTENER_FAULT; // see R5
      end else if (io.timed_out || io.cancelled) begin
        code = IO_ABORTED_FAULT; // see R10
      end
    end
  end

endmodule : bsr_bus_classify
`default_nettype wire

//--- rtl/bsr_fault_reporter.sv
/*
  bsr_fault_reporter: records the outcome of each programming message as
  an instrument-bus fault code, a serial-link fault code and the fault
  flag of the status word; decides discard of faulty messages and abort
  of transfers on serial faults.
  Assumes a message parser that consumes characters with chr_ready,
  presents one decoded request per message and reports I/O completion.
*/
// Operation
// R1: fault flag follows error of last call
// R2: flagged fault always names its cause code
// R3: bus code 0 when no bus error
// R4: code 1 for controller-only call without control
// R5: code 2 for missing listener or acceptor
// R6: code 3 unaddressed or shadow without ATN
// R7: code 4 for out-of-range arguments
// R8: bad argument means no execution at all
// R9: code 5 without system controller; default role
// R10: code 6 when I/O is cancelled
// R11: code 11 for disabled capability or mode
// R12: code 14 when command bytes fail
// R13: code 17 for unrecognised function name
// R14: host ends each message with CR/LF
// R15: simple set discards message on link fault
// R16: link fault aborts running data transfer
// R17: ignore mode keeps bytes, records nothing
// R18: link code 0 when no serial error
// R19: link code 1 on parity mismatch
// R20: link code 2 on receiver overrun
// R21: link code 3 on buffer overflow
// R22: framing fault when stop bit misplaced
// R23: long low line is break, framing fault
// R24: indicators held until next message completes
`timescale 1ns/10ps
`default_nettype none
module bsr_fault_reporter
  import bsr_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // serial line and configuration
  input  wire logic        rx_line,
  input  wire bsr_cfg_t    cfg,
  // characters to the parser
  output bsr_chr_t         chr_q,
  input  wire logic        chr_ready,
  input  wire logic        buf_full,
  // decoded request and bus state
  input  wire logic        req_valid,
  input  wire bsr_req_t    req,
  input  wire bsr_bus_t    bus,
  // execution handshake
  output logic             go_q,
  input  wire logic        xfer_active,
  input  wire logic        io_done,
  input  wire bsr_io_t     io,
  output logic             abort_q,
  output logic             discard_q,
  // recorded outcome, system controller role and ignore switch
  output logic             done_q,
  output logic [15:0]      status_q,
  output logic [4:0]       bus_code_q,
  output logic [2:0]       link_code_q,
  output logic             sys_ctrl_q,
  output logic             ign_q
);

  // receiver outputs
  logic       rx_valid;  // character complete
  logic [7:0] rx_data;   // character value
  logic       rx_par;    // parity mismatch
  logic       rx_frm;    // stop bit missing
  logic       rx_brk;    // break seen

  // fault detection
  logic       lost_ovr;  // previous char still unread
  logic       lost_ofl;  // parser buffer full
  logic [2:0] link_ev;   // fault of this cycle
  logic       err_ev;    // fault that counts
  logic       deliver;   // char goes to parser
  logic       term;      // terminator consumed

  // message and execution state
  bsr_state_t st_q;       // execution state
  bsr_req_t   req_q;      // request under execution
  logic [2:0] pend_q;     // first link fault of message
  logic       msg_bad_q;  // message hit a link fault
  bsr_req_t   cls_req;    // request seen by classifier
  logic [4:0] cls_code;   // classifier result
  logic       rec;        // record an outcome now
  logic [4:0] rec_bus;    // bus code to record

  // serial receiver
  bsr_rx_check #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clk       (clk),
    .arst_n    (arst_n),
    .rx_line   (rx_line),
    .par_en    (cfg.par_en),
    .par_odd   (cfg.par_odd),
    .chr_valid (rx_valid),
    .chr_data  (rx_data),
    .par_err   (rx_par),
    .frm_err   (rx_frm),
    .brk       (rx_brk)
  );

  // classifier sees the held request while executing
  assign cls_req = (st_q == ST_EXEC) ? req_q : req;

  bsr_bus_classify u_cls (
    .req      (cls_req),
    .bus      (bus),
    .io       (io),
    .post     (st_q == ST_EXEC),
    .sys_ctrl (sys_ctrl_q),
    .code     (cls_code)
  );

  // character loss conditions
  assign lost_ovr = rx_valid && chr_q.valid && !chr_ready; // see R20
  assign lost_ofl = rx_valid && buf_full && !lost_ovr;     // see R21

  // per-cycle link fault, framing first
  always_comb begin
    link_ev = LINK_NO_FAULT_CODE; // see R18
    if (rx_brk || (rx_valid && rx_frm)) begin
      link_ev = FRAMING_FAULT; // see R22 R23
    end else if (rx_valid && rx_par) begin
      link_ev = PARITY_FAULT; // see R19
    end else if (lost_ovr) begin
      link_ev = OVERRUN_FAULT; // see R20
    end else if (lost_ofl) begin
      link_ev = BUFFER_OVERFLOW_FAULT; // see R21
    end
  end

  // ignore mode suppresses every link fault
  assign err_ev = (link_ev != LINK_NO_FAULT_CODE) && !ign_q; // see R17

  // bad chars are dropped unless faults are ignored
  assign deliver = rx_valid && !lost_ovr && !lost_ofl
                   && (ign_q || (!rx_par && !rx_frm)); // see R17

  // host closes each message with CR or LF
  assign term = chr_q.valid && chr_ready
                && (chr_q.data == CHAR_CR || chr_q.data == CHAR_LF); // see R14

  // character hand-off register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chr_q <= '0;
    end else if (deliver) begin
      chr_q.valid <= 1'b1;
      chr_q.data  <= rx_data;
    end else if (chr_ready) begin
      chr_q.valid <= 1'b0;
    end
  end

  // first link fault since the last recorded outcome
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= LINK_NO_FAULT_CODE;
    end else if (err_ev && (pend_q == LINK_NO_FAULT_CODE || rec)) begin
      pend_q <= link_ev; // new fault wins over the clear
    end else if (rec) begin
      pend_q <= LINK_NO_FAULT_CODE;
    end
  end

  // message marked for discard in the simple command set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_bad_q <= 1'b0;
    end else if (err_ev && cfg.smode && !xfer_active) begin
      msg_bad_q <= 1'b1; // see R15
    end else if (term) begin
      msg_bad_q <= 1'b0;
    end
  end

  // discard at the terminator of a faulty message
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= term && msg_bad_q && cfg.smode; // see R15
    end
  end

  // abort the data transfer in progress
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= err_ev && xfer_active; // see R16
    end
  end

  // when an outcome is recorded and with which bus code
  always_comb begin
    rec     = 1'b0;
    rec_bus = BUS_NO_FAULT_CODE;
    if (st_q == ST_EXEC) begin
      if (io_done) begin
        rec     = 1'b1;
        rec_bus = cls_code;
      end
    end else if (req_valid && cls_code != BUS_NO_FAULT_CODE) begin
      rec     = 1'b1;
      rec_bus = cls_code; // see R8
    end else if (term && msg_bad_q && cfg.smode) begin
      rec = 1'b1; // see R15
    end
  end

  // execution state machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= ST_IDLE;
      req_q <= '0;
      go_q  <= 1'b0;
    end else begin
      go_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (req_valid && cls_code == BUS_NO_FAULT_CODE) begin
            go_q  <= 1'b1; // see R8
            req_q <= req;
            st_q  <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (io_done) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // system controller role, held from power-on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_ctrl_q <= 1'b1; // see R9
    end else if (st_q == ST_IDLE && req_valid && cls_code == BUS_NO_FAULT_CODE
                 && req.func == FN_RSC) begin
      sys_ctrl_q <= (req.arg != 32'h0000_0000);
    end
  end

  // ignore-serial-faults switch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ign_q <= 1'b0;
    end else if (st_q == ST_IDLE && req_valid && cls_code == BUS_NO_FAULT_CODE
                 && req.func == FN_SPIGN) begin
      ign_q <= (req.arg != 32'h0000_0000); // see R17
    end
  end

  // outcome indicators, held between messages
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q      <= 1'b0;
      bus_code_q  <= BUS_NO_FAULT_CODE;
      link_code_q <= LINK_NO_FAULT_CODE;
      status_q    <= STATUS_RESET;
    end else begin
      done_q <= rec;
      if (rec) begin
        bus_code_q  <= rec_bus; // see R24
        link_code_q <= pend_q;  // see R2 R24
        status_q[STATUS_FAULT_POS] <= (rec_bus != BUS_NO_FAULT_CODE)
                                      || (pend_q != LINK_NO_FAULT_CODE); // see R1
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_bad_tmo;
    st_q == ST_IDLE && req_valid && req.func == FN_TMO && req.arg == 32'h0
    && !req.unknown_name && !req.mode_mismatch;
  endsequence

  sequence s_rejected;
    !go_q && done_q && bus_code_q == BAD_ARGUMENT_FAULT;
  endsequence

  a_fault_flag_cause: assert property ( // see R2
    status_q[STATUS_FAULT_POS] |->
      (bus_code_q != BUS_NO_FAULT_CODE || link_code_q != LINK_NO_FAULT_CODE))
    else $error("fault flag without a cause code");

  a_fault_flag_clear: assert property ( // see R1
    done_q && bus_code_q == BUS_NO_FAULT_CODE && link_code_q == LINK_NO_FAULT_CODE
    |-> !status_q[STATUS_FAULT_POS])
    else $error("fault flag left set after clean call");

  a_bad_arg_reject: assert property ( // see R8
    s_bad_tmo |=> s_rejected ##1 (st_q == ST_IDLE))
    else $error("bad argument was executed");

  a_no_sysctrl_code: assert property ( // see R9
    st_q == ST_IDLE && req_valid && req.func == FN_SRE && !sys_ctrl_q
    && !req.unknown_name && !req.mode_mismatch
    |=> done_q && bus_code_q == NO_SYSTEM_CONTROLLER_FAULT)
    else $error("missing system controller fault");

  a_indicator_hold: assert property ( // see R24
    !rec |=> $stable(bus_code_q) && $stable(link_code_q))
    else $error("indicator changed without completion");

  a_link_discard: assert property ( // see R15
    term && msg_bad_q && cfg.smode && st_q == ST_IDLE && !req_valid
    |=> discard_q && done_q && bus_code_q == BUS_NO_FAULT_CODE && !msg_bad_q)
    else $error("faulty message not discarded");

  a_xfer_abort: assert property ( // see R16
    rx_valid && rx_par && !ign_q && xfer_active |=> abort_q)
    else $error("transfer not aborted on link fault");

  a_ignore_keeps: assert property ( // see R17
    ign_q && rx_valid && rx_par && !lost_ovr && !lost_ofl
    |=> chr_q.valid && chr_q.data == $past(rx_data) && !abort_q)
    else $error("errored byte dropped in ignore mode");

  a_break_framing: assert property ( // see R23
    rx_brk && !ign_q && pend_q == LINK_NO_FAULT_CODE && !rec
    |=> pend_q == FRAMING_FAULT)
    else $error("break not recorded as framing fault");

endmodule : bsr_fault_reporter
`default_nettype wire

//--- rtl/bsr_rx_check.sv
/*
  bsr_rx_check: asynchronous serial receiver with parity, framing and
  break detection. Assumes rx_line is already synchronous; idle is high.
*/
`timescale 1ns/10ps
`default_nettype none
module bsr_rx_check
  import bsr_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // line and format
  input  wire logic       rx_line,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  // received character; chr_valid and brk are one-cycle pulses, the rest hold
  output logic            chr_valid,
  output logic [7:0]      chr_data,
  output logic            par_err,
  output logic            frm_err,
  output logic            brk
);

  localparam int unsigned CW  = $clog2(BIT_CYCLES + 1);
  localparam int unsigned LIM = BIT_CYCLES * (DATA_BITS + 3);
  localparam int unsigned BW  = $clog2(LIM + 2);

  bsr_rx_state_t  st_q;   // receiver state
  logic [CW-1:0]  cnt_q;  // cycles to next sample
  logic [2:0]     idx_q;  // data bit index
  logic [7:0]     sh_q;   // data shift register
  logic           par_q;  // received parity bit
  logic [BW-1:0]  lo_q;   // cycles the line has been low
  logic [BW-1:0]  lim;    // one character time for this format
  logic           line_q; // line at the previous edge

  assign lim = BW'(BIT_CYCLES * (DATA_BITS + 2)) + (par_en ? BW'(BIT_CYCLES) : '0);

  // character framing state machine, samples mid-bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= RX_IDLE;
      cnt_q     <= '0;
      idx_q     <= '0;
      sh_q      <= 8'h00;
      par_q     <= 1'b0;
      chr_valid <= 1'b0;
      chr_data  <= 8'h00;
      par_err   <= 1'b0;
      frm_err   <= 1'b0;
      line_q    <= 1'b1; // mark, so a line already low on leaving reset counts as a start edge
    end else begin
      chr_valid <= 1'b0;
      line_q    <= rx_line;
      case (st_q)
        RX_IDLE: begin
          // start only on a falling edge: a break must not decode again
          if (line_q && !rx_line) begin
            st_q  <= RX_START;
            cnt_q <= CW'(BIT_CYCLES / 2);
          end
        end
        RX_START: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (!rx_line) begin
            st_q  <= RX_DATA;
            cnt_q <= CW'(BIT_CYCLES - 1);
            idx_q <= '0;
          end else begin
            st_q <= RX_IDLE; // glitch, not a start bit
          end
        end
        RX_DATA: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            sh_q  <= {rx_line, sh_q[7:1]};
            idx_q <= idx_q + 1'b1;
            cnt_q <= CW'(BIT_CYCLES - 1);
            if (idx_q == 3'(DATA_BITS - 1)) begin
              st_q <= par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            par_q <= rx_line;
            cnt_q <= CW'(BIT_CYCLES - 1);
            st_q  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            chr_valid <= 1'b1;
            chr_data  <= sh_q;
            frm_err   <= !rx_line; // see R22
            par_err   <= par_en && ((^sh_q ^ par_q) != par_odd); // see R19
            st_q      <= RX_IDLE;
          end
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end

  // break: line low longer than one whole character
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_q <= '0;
      brk  <= 1'b0;
    end else begin
      brk <= 1'b0;
      if (rx_line) begin
        lo_q <= '0;
      end else if (lo_q <= lim) begin
        lo_q <= lo_q + 1'b1;
        brk  <= (lo_q == lim); // see R23
      end
    end
  end

endmodule : bsr_rx_check
`default_nettype wire

//--- tb/bsr_host_model.sv
/*
  bsr_host_model: host side of the serial link, sends framed characters
  and breaks. Assumes it is called at a falling clock edge; idle is high.
*/
`timescale 1ns/10ps
`default_nettype none
module bsr_host_model #(
  parameter int unsigned BIT_CYCLES = 8
)(
  // clock and format
  input  wire logic clk,
  input  wire logic par_en,
  input  wire logic par_odd,
  // line into the device
  output logic      rx_line
);
  // line rests at mark between frames
  initial rx_line = 1'b1;

  // start, 8 data bits lsb first, parity when par_en, stop, then two idle bit times
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, (^d) ^ par_odd ^ bad_par, d, 1'b0};
    if (!par_en) begin
      f[9] = ~bad_stop;
    end
    for (int i = 0; i < (par_en ? 11 : 10); i++) begin
      rx_line = f[i];
      repeat (BIT_CYCLES) @(negedge clk);
    end
    rx_line = 1'b1;
    repeat (2 * BIT_CYCLES) @(negedge clk);
  endtask : send

  // line held low well beyond one character time
  task automatic brk();
    rx_line = 1'b0;
    repeat (14 * BIT_CYCLES) @(negedge clk);
    rx_line = 1'b1;
    repeat (4 * BIT_CYCLES) @(negedge clk);
  endtask : brk
endmodule : bsr_host_model
`default_nettype wire

//--- tb/tb_bsr_fault_reporter.sv
/*
  tb_bsr_fault_reporter: request and serial scenarios with expected codes.
  Assumes BIT_CYCLES of 8 and inputs driven at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_bsr_fault_reporter;
  import bsr_pkg::*;
  logic clk, arst_n, rx_line, chr_ready, buf_full, req_valid, xfer_active, io_done;
  logic go_q, abort_q, discard_q, done_q, sys_ctrl_q, ign_q;
  bsr_cfg_t cfg;
  bsr_chr_t chr_q;
  bsr_req_t req;
  bsr_bus_t bus;
  bsr_io_t io;
  logic [15:0] status_q;
  logic [4:0] bus_code_q;
  logic [2:0] link_code_q;
  int num_errors, checked, aborts;

  bsr_fault_reporter #(.BIT_CYCLES(8)) i_dut (.clk(clk), .arst_n(arst_n), .rx_line(rx_line),
    .cfg(cfg), .chr_q(chr_q), .chr_ready(chr_ready), .buf_full(buf_full),
    .req_valid(req_valid), .req(req), .bus(bus), .go_q(go_q), .xfer_active(xfer_active),
    .io_done(io_done), .io(io), .abort_q(abort_q), .discard_q(discard_q), .done_q(done_q),
    .status_q(status_q), .bus_code_q(bus_code_q), .link_code_q(link_code_q),
    .sys_ctrl_q(sys_ctrl_q), .ign_q(ign_q));
  bsr_host_model #(.BIT_CYCLES(8)) i_host (.clk(clk), .par_en(cfg.par_en),
    .par_odd(cfg.par_odd), .rx_line(rx_line));

  // clock and abort pulse counter
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (abort_q === 1'b1) aborts <= aborts + 1;

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // one message: request, optional execution with outcome, recorded codes
  task automatic run(input bsr_func_t f, input logic [31:0] a, input logic [2:0] fl,
                     input logic [5:0] o, input logic eg, input logic [4:0] eb,
                     input logic [2:0] el);
    req = '{f, a, fl[2], fl[1], fl[0]};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    chk(go_q, eg, "go");
    if (go_q === 1'b1) begin
      io = o;
      io_done = 1'b1;
      @(negedge clk);
      io_done = 1'b0;
    end
    chk(done_q, 1'b1, "done");
    chk(bus_code_q, eb, "bus code");
    chk(link_code_q, el, "link code");
    chk(status_q, {(eb != 5'h00) || (el != 3'h0), 15'h0000}, "status");
    repeat (3) @(negedge clk);
    chk(bus_code_q, eb, "bus code held");
  endtask : run

  // wait for a character, compare it, consume it
  task automatic take(input logic [7:0] d);
    int k;
    k = 0;
    while (chr_q.valid !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk(k < 300, 1'b1, "char timeout");
    if (k >= 300) conclude();
    chk(chr_q.data, d, "char data");
    chr_ready = 1'b1;
    @(negedge clk);
    chr_ready = 1'b0;
  endtask : take

  initial begin
    {arst_n, chr_ready, buf_full, req_valid, xfer_active, io_done} = '0;
    {num_errors, checked, aborts} = '0;
    cfg = '{1'b0, 1'b1, 1'b0};
    req = '0;
    io = '0;
    bus = '{1'b1, 1'b1, 1'b1, 1'b1};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    chk({sys_ctrl_q, ign_q, status_q}, 18'h20000, "reset state");
    chk({bus_code_q, link_code_q}, 8'h00, "reset codes");
    // refused before execution
    run(FN_OTHER, 32'h0, 3'b001, 6'h00, 1'b0, 5'h11, 3'h0);
    run(FN_OTHER, 32'h0, 3'b010, 6'h00, 1'b0, 5'h0B, 3'h0);
    run(FN_TMO, 32'h0, 3'b000, 6'h00, 1'b0, 5'h04, 3'h0);
    run(FN_TMO, 32'h1575_2A01, 3'b000, 6'h00, 1'b0, 5'h04, 3'h0);
    run(FN_SIC, 32'h9, 3'b000, 6'h00, 1'b0, 5'h04, 3'h0);
    run(FN_CADDR, 32'h1F, 3'b000, 6'h00, 1'b0, 5'h04, 3'h0);
    bus = '{1'b0, 1'b0, 1'b0, 1'b0};
    run(FN_CMD, 32'h0, 3'b100, 6'h00, 1'b0, 5'h01, 3'h0);
    run(FN_WRT, 32'h0, 3'b000, 6'h00, 1'b0, 5'h03, 3'h0);
    run(FN_GTS_SHADOW, 32'h0, 3'b000, 6'h00, 1'b0, 5'h03, 3'h0);
    bus = '{1'b1, 1'b1, 1'b1, 1'b1};
    // executed, outcome from the transfer; SIC and SRE refused without system controller
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h0);
    run(FN_WRT, 32'h0, 3'b000, 6'h02, 1'b1, 5'h02, 3'h0);
    run(FN_WRT, 32'h0, 3'b000, 6'h08, 1'b1, 5'h02, 3'h0);
    run(FN_CMD, 32'h0, 3'b000, 6'h04, 1'b1, 5'h02, 3'h0);
    run(FN_RD, 32'h0, 3'b000, 6'h10, 1'b1, 5'h06, 3'h0);
    run(FN_RD, 32'h0, 3'b000, 6'h01, 1'b1, 5'h0E, 3'h0);
    run(FN_RSC, 32'h0, 3'b000, 6'h00, 1'b1, 5'h00, 3'h0);
    run(FN_SIC, 32'h64, 3'b000, 6'h00, 1'b0, 5'h05, 3'h0);
    run(FN_SRE, 32'h0, 3'b000, 6'h00, 1'b0, 5'h05, 3'h0);
    run(FN_RSC, 32'h1, 3'b000, 6'h00, 1'b1, 5'h00, 3'h0);
    // serial faults, recorded by the next message
    i_host.send(8'h41, 1'b0, 1'b0);
    take(8'h41);
    i_host.send(8'h41, 1'b1, 1'b0);
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h1);
    cfg.par_odd = 1'b1;
    i_host.send(8'h41, 1'b0, 1'b1);
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h4);
    fork
      i_host.brk();
      begin
        repeat (87) @(negedge clk);
        run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h4);
      end
    join
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h4);
    i_host.send(8'h41, 1'b0, 1'b0);
    i_host.send(8'h42, 1'b0, 1'b0);
    take(8'h41);
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h2);
    buf_full = 1'b1;
    i_host.send(8'h43, 1'b0, 1'b0);
    buf_full = 1'b0;
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h3);
    xfer_active = 1'b1;
    i_host.send(8'h41, 1'b1, 1'b0);
    xfer_active = 1'b0;
    chk(aborts, 1, "abort pulses");
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h1);
    // simple set: faulty message discarded at its terminator
    cfg.smode = 1'b1;
    i_host.send(8'h41, 1'b1, 1'b0);
    i_host.send(CHAR_CR, 1'b0, 1'b0);
    take(CHAR_CR);
    chk({discard_q, done_q, link_code_q}, 5'h19, "discard");
    chk(status_q, 16'h8000, "discard flag");
    cfg = '{1'b0, 1'b0, 1'b1};
    repeat (2) @(negedge clk);
    i_host.send(8'h45, 1'b1, 1'b0);
    take(8'h45);
    cfg.par_en = 1'b1;
    // ignore mode keeps the faulty byte and records nothing
    run(FN_SPIGN, 32'h1, 3'b000, 6'h00, 1'b1, 5'h00, 3'h0);
    chk(ign_q, 1'b1, "ignore mode");
    i_host.send(8'h44, 1'b1, 1'b0);
    take(8'h44);
    run(FN_TMO, 32'h64, 3'b000, 6'h00, 1'b1, 5'h00, 3'h0);
    conclude();
  end
endmodule : tb_bsr_fault_reporter
`default_nettype wire
